// File: pkg/spi_port_pkg.sv
// Constants, register map and types shared by the SPI port design
// Operation
// R01: Mode codes 0-4 master, 5 slave, 6 I2C slave, 7 serial function off.
// R02: Master clock is system clock /4, /16, /64, sub clock, or timer match/2.
// R03: Slave makes no clock; it shifts on the external master's clock.
// R04: Enable low releases data, clock and select pins and stops activity.
// R05: Raising enable keeps control register contents; nothing is reset.
// R06: Slave select rising mid-byte, with select pin enabled, sets incomplete and complete.
// R07: Setting the incomplete flag raises the module interrupt request.
// R08: Software writing 1 to incomplete sets only that flag, not complete.
// R09: Polarity 0 idles the clock high; polarity 1 idles it low.
// R10: Capture on rising edge for polarity/edge 0/0 or 1/1, else falling.
// R11: Software sets polarity and edge bits before starting a transfer.
// R12: Shift order 0 sends LSB first; 1 sends MSB first.
// R13: Select pin enable 0 releases the select pin; 1 makes it active-low select.
// R14: Data write during a transfer is dropped and sets write collision until cleared.
// R15: Complete flag sets when a byte ends, reads 0 during transfer, software clears. Besides software, only a master start clears it; a slave start does not.
// R16: One 8-bit buffer holds byte to send and byte received.
// R17: Format bits 7-6 are plain storage; mode register bit 4 reads zero.
// R18: Master with enable: writing the buffer starts a one-byte exchange at once.
// R19: Slave with select pin disabled is always selected, ignoring the select line.
// R20: External master asserts select before giving any clock edges.
// R21: A byte is eight bits; master returns clock to idle after the eighth.
package spi_port_pkg;

  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam int          BYTE_W        = 8;

  // Word addresses of the three registers
  localparam logic [3:0]  OFS_MODE_CTRL = 4'h0;
  localparam logic [3:0]  OFS_DATA_BUF  = 4'h4;
  localparam logic [3:0]  OFS_FMT_CTRL  = 4'h8;

  // Mode control fields
  localparam int          MODE_HI       = 7;
  localparam int          MODE_LO       = 5;
  localparam int          DEB_HI        = 3;
  localparam int          DEB_LO        = 2;
  localparam int          EN_BIT        = 1;
  localparam int          ICF_BIT       = 0;

  // Format control fields
  localparam int          SPARE_HI      = 7;
  localparam int          SPARE_LO      = 6;
  localparam int          POL_BIT       = 5;
  localparam int          EDGE_BIT      = 4;
  localparam int          ORDER_BIT     = 3;
  localparam int          SELECT_PIN_ENABLE_BIT      = 2;
  localparam int          WRITE_COLLISION_FLAG_BIT      = 1;
  localparam int          TRF_BIT       = 0;

  // Operating mode codes
  localparam logic [2:0]  MODE_DIV4     = 3'h0;
  localparam logic [2:0]  MODE_DIV16    = 3'h1;
  localparam logic [2:0]  MODE_DIV64    = 3'h2;
  localparam logic [2:0]  MODE_SUB      = 3'h3;
  localparam logic [2:0]  MODE_TIMER    = 3'h4;
  localparam logic [2:0]  MODE_SLAVE    = 3'h5;
  localparam logic [2:0]  MODE_I2C      = 3'h6;
  localparam logic [2:0]  MODE_OFF      = 3'h7;

  // Reset values
  localparam logic [2:0]  MODE_RST      = 3'h7;
  localparam logic [1:0]  DEB_RST       = 2'h0;
  localparam logic [7:0]  FMT_RST       = 8'h00;
  localparam logic [7:0]  DATA_RST      = 8'h00;

  // Half periods of the divided master clock, in system clocks
  localparam logic [4:0]  HALF_DIV4     = 5'h02;
  localparam logic [4:0]  HALF_DIV16    = 5'h08;
  localparam logic [4:0]  HALF_DIV64    = 5'h20;

  // Clock toggles in one byte and index of the last captured bit
  localparam logic [4:0]  TOGGLES_BYTE  = 5'h10;
  localparam logic [2:0]  LAST_BIT      = 3'h7;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {MC_MASTER, MC_SLAVE, MC_I2C, MC_OFF} mode_class_t;
  typedef enum logic       {XS_IDLE, XS_RUN} xfer_state_t;

endpackage

// File: src/spi_clk_tick.sv
// Master clock toggle tick generator: divider, sub clock edges, timer matches
`timescale 1ns/10ps
module spi_clk_tick
  import spi_port_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] mode,
  input  wire logic       sub_clk_s,
  input  wire logic       timer_match,
  output logic            tick
);
  logic [4:0] cnt_r;
  logic       sub_d_r;
  logic [4:0] half;

  // Half period for the divided sources
  always_comb begin
    case (mode)
      MODE_DIV4:  half = HALF_DIV4;
      MODE_DIV16: half = HALF_DIV16;
      default:    half = HALF_DIV64;
    endcase
  end

  // Divider restarts with each transfer so the first half period is whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r   <= 5'h00;
      sub_d_r <= 1'b0;
      tick    <= 1'b0;
    end else if (ce) begin
      sub_d_r <= sub_clk_s;
      tick    <= 1'b0;
      if (!run) begin
        cnt_r <= 5'h00;
      end else begin
        case (mode)
          MODE_SUB:   tick <= sub_clk_s ^ sub_d_r;   // Both sub clock edges [R02]
          MODE_TIMER: tick <= timer_match;           // Toggle per match: match/2 [R02]
          default: begin
            if (cnt_r == half - 5'h01) begin        // /4, /16, /64 [R02]
              cnt_r <= 5'h00;
              tick  <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
        endcase
      end
    end
  end
endmodule // spi_clk_tick

// File: src/spi_port.sv
// SPI master/slave port with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module spi_port (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                             ce,
  // AXI4-Lite slave
  input  wire logic [spi_port_pkg::ADDR_W-1:0]  s_awaddr,
  input  wire logic                             s_awvalid,
  output logic                                  s_awready,
  input  wire logic [spi_port_pkg::DATA_W-1:0]  s_wdata,
  input  wire logic [3:0]                       s_wstrb,
  input  wire logic                             s_wvalid,
  output logic                                  s_wready,
  output logic [1:0]                            s_bresp,
  output logic                                  s_bvalid,
  input  wire logic                             s_bready,
  input  wire logic [spi_port_pkg::ADDR_W-1:0]  s_araddr,
  input  wire logic                             s_arvalid,
  output logic                                  s_arready,
  output logic [spi_port_pkg::DATA_W-1:0]       s_rdata,
  output logic [1:0]                            s_rresp,
  output logic                                  s_rvalid,
  input  wire logic                             s_rready,
  // Clock sources
  input  wire logic                             sub_clk,
  input  wire logic                             timer_match,
  // Serial pins
  input  wire logic                             sck_in,
  output logic                                  sck_out,
  output logic                                  sck_oe,
  input  wire logic                             sdi_in,
  output logic                                  sdo_out,
  output logic                                  sdo_oe,
  input  wire logic                             slave_select_n,
  output logic                                  select_pin_active,
  // Module interrupt request
  output logic                                  irq_pulse
);
  import spi_port_pkg::*;

  // Registers
  logic [2:0]  mode_r;
  logic [1:0]  deb_r;
  logic        en_r;
  logic        icf_r;
  logic [1:0]  spare_r;
  logic        pol_r;
  logic        edge_r;
  logic        order_r;
  logic        select_pin_enable_r;
  logic        write_collision_flag_r;
  logic        trf_r;
  logic [7:0]  data_r;

  // Engine
  xfer_state_t state_r;
  logic [7:0]  sh_r;
  logic [2:0]  bit_cnt_r;
  logic        pend_r;
  logic        samp_r;
  logic [4:0]  tog_r;
  logic        sck_r;

  // Bus
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wdata_r;
  logic              wlane_r;
  logic              aw_got_r;
  logic              w_got_r;

  // Synchronised pins
  logic        sck_s;
  logic        sdi_s;
  logic        ss_n_s;
  logic        sub_s;
  logic        sck_d_r;
  logic        ss_d_r;
  logic        tick;

  mode_class_t mclass;
  logic        is_master;
  logic        is_slave;
  logic        selected;
  logic        in_prog;
  logic        wr_fire;
  logic        wr_ok;
  logic        wr_mode;
  logic        wr_data;
  logic        wr_fmt;
  logic        data_take;
  logic        start;
  logic        m_tog;
  logic        cap_rise;
  logic        ev_cap;
  logic        ev_sh;
  logic        byte_done;
  logic        m_done;
  logic        incomplete;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  // Shift one bit into the byte in the selected order
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic msb_first);
    shift_in = msb_first ? {v[6:0], b} : {b, v[7:1]};        // [R12]
  endfunction

  spi_sync2 #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({sck_in, sdi_in, slave_select_n, sub_clk}),
    .q       ({sck_s, sdi_s, ss_n_s, sub_s})
  );

  spi_clk_tick u_tick (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .run         (state_r == XS_RUN),
    .mode        (mode_r),
    .sub_clk_s   (sub_s),
    .timer_match (timer_match),
    .tick        (tick)
  );

  // Mode decode
  always_comb begin
    case (mode_r)
      MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_SUB, MODE_TIMER: mclass = MC_MASTER; // [R01]
      MODE_SLAVE: mclass = MC_SLAVE;                                               // [R01]
      MODE_I2C:   mclass = MC_I2C;                                                 // [R01]
      default:    mclass = MC_OFF;                                                 // [R01]
    endcase
  end

  // Enable gates everything that touches the pins
  assign is_master = en_r && (mclass == MC_MASTER);                     // [R04]
  assign is_slave  = en_r && (mclass == MC_SLAVE);                      // [R04]
  assign selected  = !select_pin_enable_r || !ss_n_s;                                // [R19] [R13]
  assign in_prog   = (state_r == XS_RUN) || (is_slave && (bit_cnt_r != 3'h0 || pend_r));
  assign cap_rise  = (pol_r == edge_r);                                 // [R10]

  // Master edges come from the tick; slave edges from the external clock
  assign m_tog  = is_master && (state_r == XS_RUN) && tick;
  always_comb begin
    ev_cap = 1'b0;
    ev_sh  = 1'b0;
    if (m_tog) begin
      ev_cap = (!sck_r == cap_rise);                                    // [R10]
      ev_sh  = (!sck_r != cap_rise);
    end else if (is_slave && selected) begin                            // [R03]
      ev_cap = cap_rise ? (sck_s && !sck_d_r) : (!sck_s && sck_d_r);    // [R10]
      ev_sh  = cap_rise ? (!sck_s && sck_d_r) : (sck_s && !sck_d_r);
    end
  end

  assign byte_done  = ev_cap && (bit_cnt_r == LAST_BIT);                // [R21]
  assign m_done     = m_tog && (tog_r == TOGGLES_BYTE - 5'h01);         // [R21]
  // A select release counts only once a bit has moved
  assign incomplete = is_slave && select_pin_enable_r && ss_n_s && !ss_d_r &&
                      (bit_cnt_r != 3'h0 || pend_r);                    // [R06]

  // Bus write decode
  assign wr_fire   = aw_got_r && w_got_r && !s_bvalid;
  assign wr_ok     = wr_fire && wlane_r;
  assign wr_mode   = wr_ok && (awaddr_r == OFS_MODE_CTRL);
  assign wr_data   = wr_ok && (awaddr_r == OFS_DATA_BUF);
  assign wr_fmt    = wr_ok && (awaddr_r == OFS_FMT_CTRL);
  assign data_take = wr_data && !in_prog;                               // [R14]
  assign start     = data_take && is_master;                            // [R18]

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      s_awready <= 1'b0;
      awaddr_r  <= '0;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_got_r  <= 1'b1;
        s_awready <= 1'b0;
        awaddr_r  <= {s_awaddr[ADDR_W-1:2], 2'b00};
      end else if (wr_fire) begin
        aw_got_r  <= 1'b0;
        s_awready <= 1'b1;
      end else if (!aw_got_r) begin
        s_awready <= 1'b1;
      end
    end
  end

  // Write data channel; only byte lane 0 holds register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r  <= 1'b0;
      s_wready <= 1'b0;
      wdata_r  <= 8'h00;
      wlane_r  <= 1'b0;
    end else if (ce) begin
      if (s_wvalid && s_wready) begin
        w_got_r  <= 1'b1;
        s_wready <= 1'b0;
        wdata_r  <= s_wdata[BYTE_W-1:0];
        wlane_r  <= s_wstrb[0];
      end else if (wr_fire) begin
        w_got_r  <= 1'b0;
        s_wready <= 1'b1;
      end else if (!w_got_r) begin
        s_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (awaddr_r == OFS_MODE_CTRL || awaddr_r == OFS_DATA_BUF ||
                     awaddr_r == OFS_FMT_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    rd_hit  = 1'b1;
    case ({s_araddr[ADDR_W-1:2], 2'b00})
      OFS_MODE_CTRL: rd_byte = {mode_r, 1'b0, deb_r, en_r, icf_r};      // [R17]
      OFS_DATA_BUF:  rd_byte = data_r;                                  // [R16]
      OFS_FMT_CTRL:  rd_byte = {spare_r, pol_r, edge_r, order_r, select_pin_enable_r, write_collision_flag_r, trf_r};
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Read channel: one read at a time, answered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rdata   <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
        s_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid  <= 1'b0;
        s_arready <= 1'b1;
      end else if (!s_rvalid) begin
        s_arready <= 1'b1;
      end
    end
  end

  // Control registers hold their values across enable changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r  <= MODE_RST;
      deb_r   <= DEB_RST;
      en_r    <= 1'b0;
      spare_r <= FMT_RST[SPARE_HI:SPARE_LO];
      pol_r   <= FMT_RST[POL_BIT];
      edge_r  <= FMT_RST[EDGE_BIT];
      order_r <= FMT_RST[ORDER_BIT];
      select_pin_enable_r  <= FMT_RST[SELECT_PIN_ENABLE_BIT];
    end else if (ce) begin
      if (wr_mode) begin                                                // [R05]
        mode_r <= wdata_r[MODE_HI:MODE_LO];
        deb_r  <= wdata_r[DEB_HI:DEB_LO];
        en_r   <= wdata_r[EN_BIT];
      end
      // Polarity changes mid-byte swap the capture and shift edges; software must avoid them
      if (wr_fmt) begin                                                 // [R11]
        spare_r <= wdata_r[SPARE_HI:SPARE_LO];                          // [R17]
        pol_r   <= wdata_r[POL_BIT];
        edge_r  <= wdata_r[EDGE_BIT];
        order_r <= wdata_r[ORDER_BIT];
        select_pin_enable_r  <= wdata_r[SELECT_PIN_ENABLE_BIT];
      end
    end
  end

  // Flags: a hardware set in the same cycle beats a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icf_r  <= 1'b0;
      write_collision_flag_r <= 1'b0;
      trf_r  <= 1'b0;
    end else if (ce) begin
      if (incomplete) begin
        icf_r <= 1'b1;                                                  // [R06]
      end else if (wr_mode) begin
        icf_r <= wdata_r[ICF_BIT];                                      // [R08]
      end
      if (wr_data && in_prog) begin
        write_collision_flag_r <= 1'b1;                                                 // [R14]
      end else if (wr_fmt) begin
        write_collision_flag_r <= wdata_r[WRITE_COLLISION_FLAG_BIT];
      end
      if (incomplete || m_done || (is_slave && byte_done)) begin
        trf_r <= 1'b1;                                                  // [R15] [R06]
      end else if (start) begin
        trf_r <= 1'b0;                                                  // [R15]
      end else if (wr_fmt) begin
        trf_r <= wdata_r[TRF_BIT];
      end
    end
  end

  // Buffer, shifter and bit counting shared by master and slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_r    <= DATA_RST;
      sh_r      <= DATA_RST;
      bit_cnt_r <= 3'h0;
      pend_r    <= 1'b0;
      samp_r    <= 1'b0;
    end else if (ce) begin
      if (data_take) begin
        data_r <= wdata_r;                                              // [R16]
        sh_r   <= wdata_r;
      end
      if (!en_r || incomplete || start) begin                           // [R04]
        bit_cnt_r <= 3'h0;
        pend_r    <= 1'b0;
      end else if (byte_done) begin
        data_r    <= shift_in(sh_r, sdi_s, order_r);                    // [R16] [R21]
        sh_r      <= shift_in(sh_r, sdi_s, order_r);
        bit_cnt_r <= 3'h0;
        pend_r    <= 1'b0;
      end else if (ev_cap) begin
        samp_r    <= sdi_s;
        pend_r    <= 1'b1;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end else if (ev_sh && pend_r) begin
        sh_r   <= shift_in(sh_r, samp_r, order_r);                      // [R12]
        pend_r <= 1'b0;
      end
    end
  end

  // Master sequencing: sixteen toggles leave the clock at idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= XS_IDLE;
      tog_r   <= 5'h00;
      sck_r   <= 1'b1;
    end else if (ce) begin
      case (state_r)
        XS_IDLE: begin
          sck_r <= !pol_r;                                              // [R09]
          tog_r <= 5'h00;
          if (start) begin
            state_r <= XS_RUN;                                          // [R18]
          end
        end
        XS_RUN: begin
          if (!is_master) begin
            state_r <= XS_IDLE;                                         // [R04]
          end else if (m_tog) begin
            sck_r <= !sck_r;                                            // [R02]
            tog_r <= tog_r + 5'h01;
            if (m_done) begin
              state_r <= XS_IDLE;                                       // [R21]
            end
          end
        end
        default: state_r <= XS_IDLE;
      endcase
    end
  end

  // Pin drivers; all released while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_d_r           <= 1'b0;
      ss_d_r            <= 1'b1;
      sck_out           <= 1'b1;
      sck_oe            <= 1'b0;
      sdo_out           <= 1'b0;
      sdo_oe            <= 1'b0;
      select_pin_active <= 1'b0;
      irq_pulse         <= 1'b0;
    end else if (ce) begin
      sck_d_r           <= sck_s;
      ss_d_r            <= ss_n_s;
      sck_out           <= sck_r;                                       // [R09]
      sck_oe            <= is_master;                                   // [R03] [R04]
      sdo_out           <= order_r ? sh_r[7] : sh_r[0];                 // [R12]
      sdo_oe            <= is_master || (is_slave && selected);         // [R04] [R20]
      select_pin_active <= en_r && select_pin_enable_r;                              // [R13] [R04]
      irq_pulse         <= incomplete || m_done || (is_slave && byte_done); // [R07] [R15]
    end
  end

endmodule // spi_port

// File: src/spi_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module spi_sync2 #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // spi_sync2

// File: tb/spi_peer_model.sv
// Behavioural SPI slave peer on the master's serial pins
`timescale 1ns/10ps
module spi_peer_model (
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic       pol,
  input  wire logic       edg,
  input  wire logic       msb,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic            sdi,
  output logic [7:0]      rx
);
  int n = 0;
  // Capture on rising edge when polarity equals edge select, shift on the other
  always @(sck) begin
    if (sck === (pol ~^ edg)) begin
      rx = msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
      n = n + 1;
    end else if (n < 8)
      sdi = msb ? tx[7-n] : tx[n];
    else
      sdi = ~sdi; // Past the byte no stale bit is shown
  end
  // First bit is ready before any clock edge
  always @(posedge load) begin
    n = 0;
    sdi = msb ? tx[7] : tx[0];
  end
endmodule // spi_peer_model

// File: tb/spi_port_props.sv
// Bus handshake and interrupt timing checks for the SPI port
`timescale 1ns/10ps
module spi_port_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic irq_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken together at one edge
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rd_taken;
    s_arvalid && s_arready;
  endsequence
  a_write_resp_lat: assert property (wr_taken |-> ##2 s_bvalid)
    else $error("write response late");
  a_read_resp_lat: assert property (rd_taken |=> s_rvalid)
    else $error("read data late");
  a_ar_refused: assert property (rd_taken |=> !s_arready)
    else $error("read address taken twice");
  a_b_drop: assert property (s_bvalid && s_bready |=> !s_bvalid)
    else $error("write response repeated");
  a_r_drop: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read data repeated");
  a_write_blocked: assert property (s_awvalid && s_awready |=> !s_awready)
    else $error("write address taken twice");
  a_read_blocked: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while answering");
  a_irq_single: assert property (irq_pulse |=> !irq_pulse)
    else $error("interrupt pulse too long");
endmodule // spi_port_props

// File: tb/spi_port_tb_top.sv
// Self-checking bench: registers, master bytes, slave abort
`timescale 1ns/10ps
module spi_port_tb_top;
  import spi_port_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, sub_clk = 0, timer_match = 0, sck_in = 1;
  logic slave_select_n = 1, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0, s_bready = 1;
  logic s_rready = 1, load = 0, pol = 0, edg = 0, msb = 0;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sck_out, sck_oe, sdi_in;
  logic sdo_out, sdo_oe, select_pin_active, irq_pulse, sdo_h;
  logic [1:0] s_bresp, s_rresp, qb[$];
  logic [7:0] ptx = 8'h00, prx, b, cfg;
  logic [33:0] qr[$];
  int miscompares = 0, total_checks = 0;

  spi_port spi_port_i (.*);
  spi_peer_model spi_peer_model_i (.sck(sck_out), .sdo(sdo_h), .pol(pol), .edg(edg),
    .msb(msb), .load(load), .tx(ptx), .sdi(sdi_in), .rx(prx));

  always #2.5 aclk = ~aclk;
  always #40 sub_clk = ~sub_clk; // Free-running sub clock, toggling on falling aclk edges, clear of the rising ones
  // Timer match: one-cycle pulse every eighth clock
  always begin
    repeat (7) @(posedge aclk);
    timer_match <= 1'b1;
    @(posedge aclk);
    timer_match <= 1'b0;
  end
  // Pre-edge copy: the last bit and the clock leave the design at one edge
  always @(negedge aclk) sdo_h <= sdo_out;

  task check(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [33:0] ok(input logic [7:0] v);
    return {26'h0, v};
  endfunction

  // Write: address and data offered together, each released once taken
  task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
    bit pa, pw;
    qb.push_back(e);
    s_awaddr <= a;
    s_wdata <= {24'($urandom), d};
    s_wstrb <= 4'($urandom) | 4'h1;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    {pa, pw} = 2'b11;
    do begin
      @(posedge aclk);
      if (pa && s_awready) begin s_awvalid <= 1'b0; pa = 0; end
      if (pw && s_wready) begin s_wvalid <= 1'b0; pw = 0; end
    end while (!s_bvalid);
    @(posedge aclk); // Registered pins follow one edge after the response
  endtask

  task rd(input logic [3:0] a, input logic [33:0] e);
    qr.push_back(e);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
  endtask

  task wait_irq;
    int n;
    n = 0;
    while (!irq_pulse && n < 5000) begin @(posedge aclk); n++; end
    if (n == 5000) miscompares++; // Missing interrupt
    repeat (2) @(posedge aclk);
  endtask

  // Results compared against the oldest note as they appear
  always @(posedge aclk) begin
    if (s_rvalid && s_rready) check("rdata", qr.pop_front(), {s_rresp, s_rdata});
    if (s_bvalid && s_bready) check("bresp", ok(qb.pop_front()), ok(s_bresp));
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    end_of_test;
  end

  initial begin
    void'($urandom(84454));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_MODE_CTRL, ok(8'he0));
    rd(OFS_FMT_CTRL, ok(8'h00));
    rd(4'hc, {RESP_SLVERR, 32'h0});
    wr(4'hc, 8'h55, RESP_SLVERR);
    wr(OFS_MODE_CTRL, 8'hfc);
    rd(OFS_MODE_CTRL, ok(8'hec));
    wr(OFS_FMT_CTRL, 8'hc0);
    rd(OFS_FMT_CTRL, ok(8'hc0));
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      {pol, edg, msb} = 3'($urandom_range(7));
      ptx = 8'($urandom);
      b = 8'($urandom);
      cfg = {2'b00, pol, edg, msb, 3'b000};
      wr(OFS_FMT_CTRL, cfg);
      wr(OFS_MODE_CTRL, {3'(i), 5'h02});
      check("sck_idle", !pol, sck_out);
      check("sck_oe", 1'b1, sck_oe);
      load = 1;
      wr(OFS_DATA_BUF, b);
      wr(OFS_DATA_BUF, ~b);
      rd(OFS_FMT_CTRL, ok(cfg | 8'h02));
      wait_irq;
      check("sck_end", !pol, sck_out);
      check("peer_rx", b, prx);
      rd(OFS_FMT_CTRL, ok(cfg | 8'h03));
      // At /4 the synchronised input trails its capture edge: transmit only
      if (i > 0) rd(OFS_DATA_BUF, ok(ptx));
      wr(OFS_FMT_CTRL, cfg);
      load = 0;
      $display("master test %0d done", i);
    end
    wr(OFS_FMT_CTRL, 8'h04);
    wr(OFS_MODE_CTRL, 8'ha2);
    check("sel_active", 1'b1, select_pin_active);
    check("slave_sck_oe", 1'b0, sck_oe);
    slave_select_n <= 1'b0;
    repeat (3) begin
      repeat (8) @(posedge aclk);
      sck_in <= 1'b0;
      repeat (8) @(posedge aclk);
      sck_in <= 1'b1;
    end
    repeat (8) @(posedge aclk);
    slave_select_n <= 1'b1;
    wait_irq;
    rd(OFS_MODE_CTRL, ok(8'ha3));
    rd(OFS_FMT_CTRL, ok(8'h05));
    wr(OFS_FMT_CTRL, 8'h04);
    wr(OFS_MODE_CTRL, 8'ha3);
    rd(OFS_FMT_CTRL, ok(8'h04));
    slave_select_n <= 1'b0;
    repeat (5) @(posedge aclk);
    check("sdo_oe_on", 1'b1, sdo_oe);
    wr(OFS_MODE_CTRL, 8'ha0);
    check("sdo_oe_off", 1'b0, sdo_oe);
    check("sel_off", 1'b0, select_pin_active);
    $display("slave test done");
    end_of_test;
  end
endmodule // spi_port_tb_top

bind spi_port spi_port_props spi_port_props_i (.*);
